// ==== logic/dcs_status.sv ====
// DMA write completion status with AXI4-Lite register access.
// Assumes per-client write issue/ack pulses and per-channel last-write
// pulses from the DMA engine, all synchronous to i_clk.
//
// What this block does
// - Status register at 0xa0, reset zero
// - Set bit only after memory accepted data
// - Set bit stays until software clears
// - Writing one clears those bits, in strobed bytes only
// - Client drained when completion is flagged
// - Bits 31..22 are ancillary B channels 9..0
// - Bits 21..6 are ancillary A channels 15..0
// - Bits 5..0 are low chroma channels 15..10
// - Masked status bits drive interrupt line
`default_nettype none

module dcs_status
(
    input  wire logic                            i_clk,
    input  wire logic                            i_nrst,
    input  wire dcs_pkg::dcs_axi_req_t           i_axi,
    output dcs_pkg::dcs_axi_rsp_t                o_axi,
    input  wire logic [31:0]                     i_last_wr,
    input  wire logic [dcs_pkg::DCS_NCLI-1:0]    i_wr_issue,
    input  wire logic [dcs_pkg::DCS_NCLI-1:0]    i_wr_ack,
    output logic      [dcs_pkg::DCS_NCLI-1:0]    o_client_empty,
    output logic                                 o_dma_irq_line_one
);

    typedef struct packed {
        dcs_pkg::dcs_axi_rsp_t                       rsp;
        dcs_pkg::dcs_wr_st_t                         wr_st;
        dcs_pkg::dcs_rd_st_t                         rd_st;
        logic                                        aw_got;
        logic [dcs_pkg::DCS_AW-1:0]                  aw_addr;
        logic                                        w_got;
        logic [31:0]                                 w_data;
        logic [3:0]                                  w_strb;
        logic [31:0]                                 mask;
        logic [31:0]                                 pend;
        logic [dcs_pkg::DCS_NCLI-1:0][dcs_pkg::DCS_OUT_W-1:0] outst;
        logic [dcs_pkg::DCS_NCLI-1:0]                empty;
        logic                                        irq;
    } dcs_state_t;

    dcs_state_t                   s_q;
    dcs_state_t                   s_d;
    logic [31:0]                  stat;
    logic [31:0]                  done_ev;
    logic [31:0]                  wr_clr;
    logic [dcs_pkg::DCS_NCLI-1:0] idle;

    // Outstanding write count update
    function automatic dcs_pkg::dcs_cnt_t next_count(
        input dcs_pkg::dcs_cnt_t c,
        input logic              inc,
        input logic              dec);
        dcs_pkg::dcs_cnt_t n;
        logic              dec_ok;
        // An acknowledge with nothing outstanding is ignored
        dec_ok = dec && (c != '0);
        n      = c;
        if (inc && !dec_ok && (c != '1))
            n = c + dcs_pkg::dcs_cnt_t'(1);
        else if (dec_ok && !inc)
            n = c - dcs_pkg::dcs_cnt_t'(1);
        return n;
    endfunction : next_count

    function automatic logic addr_mapped(
        input logic [dcs_pkg::DCS_AW-1:0] a);
        return (a == dcs_pkg::DCS_OFF_STATUS) ||
               (a == dcs_pkg::DCS_OFF_MASK);
    endfunction : addr_mapped

    always_comb
    begin
        logic [31:0] bm;
        bm      = '0;
        s_d     = s_q;
        wr_clr  = '0;
        idle    = '0;
        done_ev = '0;

        // Write address and data, taken in either order
        if (i_axi.awvalid && s_q.rsp.awready)
        begin
            s_d.aw_got  = 1'b1;
            s_d.aw_addr = i_axi.awaddr;
        end
        if (i_axi.wvalid && s_q.rsp.wready)
        begin
            s_d.w_got  = 1'b1;
            s_d.w_data = i_axi.wdata;
            s_d.w_strb = i_axi.wstrb;
        end

        // Write execution and response
        case (s_q.wr_st)
            dcs_pkg::DCS_WR_IDLE:
            begin
                if (s_d.aw_got && s_d.w_got)
                begin
                    bm = dcs_pkg::dcs_strb_mask(s_d.w_strb);
                    if (s_d.aw_addr == dcs_pkg::DCS_OFF_STATUS)
                        wr_clr = s_d.w_data & bm;
                    if (s_d.aw_addr == dcs_pkg::DCS_OFF_MASK)
                        s_d.mask = (s_q.mask & ~bm) | (s_d.w_data & bm);
                    s_d.rsp.bvalid = 1'b1;
                    s_d.rsp.bresp  = addr_mapped(s_d.aw_addr) ?
                        dcs_pkg::DCS_RESP_OKAY : dcs_pkg::DCS_RESP_SLVERR;
                    s_d.aw_got     = 1'b0;
                    s_d.w_got      = 1'b0;
                    s_d.wr_st      = dcs_pkg::DCS_WR_RESP;
                end
            end
            dcs_pkg::DCS_WR_RESP:
            begin
                if (i_axi.bready)
                begin
                    s_d.rsp.bvalid = 1'b0;
                    s_d.wr_st      = dcs_pkg::DCS_WR_IDLE;
                end
            end
            default:
            begin
                s_d.rsp.bvalid = 1'b0;
                s_d.wr_st      = dcs_pkg::DCS_WR_IDLE;
            end
        endcase
        s_d.rsp.awready = !s_d.aw_got &&
                          (s_d.wr_st == dcs_pkg::DCS_WR_IDLE);
        s_d.rsp.wready  = !s_d.w_got &&
                          (s_d.wr_st == dcs_pkg::DCS_WR_IDLE);

        // Read, no side effects on status
        case (s_q.rd_st)
            dcs_pkg::DCS_RD_IDLE:
            begin
                if (i_axi.arvalid && s_q.rsp.arready)
                begin
                    s_d.rsp.rvalid = 1'b1;
                    s_d.rsp.rresp  = dcs_pkg::DCS_RESP_OKAY;
                    if (i_axi.araddr == dcs_pkg::DCS_OFF_STATUS)
                        s_d.rsp.rdata = stat;
                    else if (i_axi.araddr == dcs_pkg::DCS_OFF_MASK)
                        s_d.rsp.rdata = s_q.mask;
                    else
                    begin
                        s_d.rsp.rdata = '0;
                        s_d.rsp.rresp = dcs_pkg::DCS_RESP_SLVERR;
                    end
                    s_d.rd_st = dcs_pkg::DCS_RD_DATA;
                end
            end
            dcs_pkg::DCS_RD_DATA:
            begin
                if (i_axi.rready)
                begin
                    s_d.rsp.rvalid = 1'b0;
                    s_d.rd_st      = dcs_pkg::DCS_RD_IDLE;
                end
            end
            default:
            begin
                s_d.rsp.rvalid = 1'b0;
                s_d.rd_st      = dcs_pkg::DCS_RD_IDLE;
            end
        endcase
        s_d.rsp.arready = (s_d.rd_st == dcs_pkg::DCS_RD_IDLE);

        // Per-client outstanding writes to external memory
        for (int unsigned c = 0; c < dcs_pkg::DCS_NCLI; c++)
        begin
            idle[c] = (s_q.outst[c] == '0) && !i_wr_issue[c];
            s_d.outst[c] = next_count(s_q.outst[c], i_wr_issue[c],
                                      i_wr_ack[c]);
            s_d.empty[c] = (s_d.outst[c] == '0);
        end

        // Completion once last write issued and all data acked
        done_ev  = s_q.pend & dcs_pkg::dcs_expand(idle);
        s_d.pend = (s_q.pend & ~done_ev) | i_last_wr;

        s_d.irq = |(stat & s_q.mask);
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            s_q             <= '0;
            s_q.wr_st       <= dcs_pkg::DCS_WR_IDLE;
            s_q.rd_st       <= dcs_pkg::DCS_RD_IDLE;
            s_q.rsp.awready <= 1'b1;
            s_q.rsp.wready  <= 1'b1;
            s_q.rsp.arready <= 1'b1;
            s_q.mask        <= dcs_pkg::DCS_MASK_RST;
            s_q.empty       <= '1;
        end
        else
            s_q <= s_d;
    end

    // Bit positions follow dcs_expand client map
    dcs_sticky u_sticky
    (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .i_set  (done_ev),
        .i_clr  (wr_clr),
        .o_stat (stat)
    );

    assign o_axi              = s_q.rsp;
    assign o_client_empty     = s_q.empty;
    assign o_dma_irq_line_one = s_q.irq;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    status_read_a: assert property (
        (i_axi.arvalid && o_axi.arready &&
         i_axi.araddr == dcs_pkg::DCS_OFF_STATUS)
        |=> (o_axi.rvalid && o_axi.rdata == $past(stat)))
        else $error("Status read at 0xa0 returned wrong data");

    set_cause_a: assert property (
        ((stat & ~$past(stat) & ~$past(done_ev)) == 32'h0000_0000))
        else $error("Status bit set without completion");

    drained_flag_a: assert property (
        (|done_ev) |=> ((o_client_empty &
            {|$past(done_ev[dcs_pkg::DCS_LOUV_HI:dcs_pkg::DCS_LOUV_LO]),
             |$past(done_ev[dcs_pkg::DCS_ANCA_HI:dcs_pkg::DCS_ANCA_LO]),
             |$past(done_ev[dcs_pkg::DCS_ANCB_HI:dcs_pkg::DCS_ANCB_LO])})
            == {|$past(done_ev[dcs_pkg::DCS_LOUV_HI:dcs_pkg::DCS_LOUV_LO]),
                |$past(done_ev[dcs_pkg::DCS_ANCA_HI:dcs_pkg::DCS_ANCA_LO]),
                |$past(done_ev[dcs_pkg::DCS_ANCB_HI:dcs_pkg::DCS_ANCB_LO])}))
        else $error("Completion flagged while client not drained");

    ancb_map_a: assert property (
        (|done_ev[dcs_pkg::DCS_ANCB_HI:dcs_pkg::DCS_ANCB_LO])
        |-> (s_q.outst[dcs_pkg::DCS_CLI_ANCB] == '0))
        else $error("Ancillary B bit set with writes pending");

    anca_map_a: assert property (
        (|done_ev[dcs_pkg::DCS_ANCA_HI:dcs_pkg::DCS_ANCA_LO])
        |-> (s_q.outst[dcs_pkg::DCS_CLI_ANCA] == '0))
        else $error("Ancillary A bit set with writes pending");

    louv_map_a: assert property (
        (|done_ev[dcs_pkg::DCS_LOUV_HI:dcs_pkg::DCS_LOUV_LO])
        |-> (s_q.outst[dcs_pkg::DCS_CLI_LOUV] == '0))
        else $error("Low chroma bit set with writes pending");

    irq_mask_a: assert property (
        ##1 (o_dma_irq_line_one == |($past(stat) & $past(s_q.mask))))
        else $error("Interrupt line disagrees with masked status");

    zero_write_a: assert property (
        (wr_clr == 32'h0000_0000) |=> (($past(stat) & ~stat) == 32'h0))
        else $error("Status bit changed without a one written");

    bvalid_hold_a: assert property (
        (o_axi.bvalid && !i_axi.bready)
        |=> (o_axi.bvalid && $stable(o_axi.bresp)))
        else $error("Write response withdrawn before taken");

    rvalid_hold_a: assert property (
        (o_axi.rvalid && !i_axi.rready)
        |=> (o_axi.rvalid && $stable(o_axi.rdata)))
        else $error("Read data changed before taken");

    unmapped_read_a: assert property (
        (i_axi.arvalid && o_axi.arready &&
         !addr_mapped(i_axi.araddr))
        |=> (o_axi.rresp == dcs_pkg::DCS_RESP_SLVERR))
        else $error("Unmapped read not refused");

    issue_count_a: assert property (
        ((s_q.outst[dcs_pkg::DCS_CLI_ANCA] == '0) &&
         i_wr_issue[dcs_pkg::DCS_CLI_ANCA])
        |=> (s_q.outst[dcs_pkg::DCS_CLI_ANCA] == dcs_pkg::dcs_cnt_t'(1)))
        else $error("Issued write lost from count");

    ack_refused_a: assert property (
        ((s_q.outst[dcs_pkg::DCS_CLI_ANCA] == '0) &&
         !i_wr_issue[dcs_pkg::DCS_CLI_ANCA])
        |=> (s_q.outst[dcs_pkg::DCS_CLI_ANCA] == '0))
        else $error("Write count moved with nothing issued");

    mask_write_a: assert property (
        (s_q.wr_st == dcs_pkg::DCS_WR_IDLE &&
         s_d.wr_st == dcs_pkg::DCS_WR_RESP &&
         s_d.aw_addr == dcs_pkg::DCS_OFF_MASK && s_d.w_strb == '1)
        |=> (s_q.mask == $past(s_d.w_data)))
        else $error("Mask register missed a full write");

endmodule : dcs_status

`default_nettype wire

// ==== logic/dcs_pkg.sv ====
// Constants, types and helpers for the DMA write completion status block.
// Assumes a 32-bit AXI4-Lite register bus and one 40 MHz clock.
`default_nettype none

package dcs_pkg;

    localparam int unsigned DCS_AW        = 12;
    localparam int unsigned DCS_DW        = 32;
    localparam int unsigned DCS_NCLI      = 3;
    localparam int unsigned DCS_OUT_W     = 8;

    // Register byte offsets and reset values
    localparam logic [11:0] DCS_OFF_STATUS = 12'h0a0;
    localparam logic [11:0] DCS_OFF_MASK   = 12'h0a4;
    localparam logic [31:0] DCS_STATUS_RST = 32'h0000_0000;
    localparam logic [31:0] DCS_MASK_RST   = 32'h0000_0000;

    // Client indices
    localparam int unsigned DCS_CLI_ANCB  = 0;
    localparam int unsigned DCS_CLI_ANCA  = 1;
    localparam int unsigned DCS_CLI_LOUV  = 2;

    // Status field positions per client
    localparam int unsigned DCS_ANCB_HI   = 31;
    localparam int unsigned DCS_ANCB_LO   = 22;
    localparam int unsigned DCS_ANCA_HI   = 21;
    localparam int unsigned DCS_ANCA_LO   = 6;
    localparam int unsigned DCS_LOUV_HI   = 5;
    localparam int unsigned DCS_LOUV_LO   = 0;

    localparam logic [1:0]  DCS_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  DCS_RESP_SLVERR = 2'h2;

    typedef logic [DCS_OUT_W-1:0] dcs_cnt_t;

    typedef enum logic [1:0]
    {
        DCS_WR_IDLE = 2'h1,
        DCS_WR_RESP = 2'h2
    } dcs_wr_st_t;

    typedef enum logic [1:0]
    {
        DCS_RD_IDLE = 2'h1,
        DCS_RD_DATA = 2'h2
    } dcs_rd_st_t;

    typedef struct packed {
        logic              awvalid;
        logic [DCS_AW-1:0] awaddr;
        logic [2:0]        awprot;
        logic              wvalid;
        logic [DCS_DW-1:0] wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [DCS_AW-1:0] araddr;
        logic [2:0]        arprot;
        logic              rready;
    } dcs_axi_req_t;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [DCS_DW-1:0] rdata;
        logic [1:0]        rresp;
    } dcs_axi_rsp_t;

    // Client that owns a status bit
    function automatic int unsigned dcs_client_of(input int unsigned b);
        int unsigned c;
        c = DCS_CLI_LOUV;
        if (b >= DCS_ANCB_LO)
            c = DCS_CLI_ANCB;
        else if (b >= DCS_ANCA_LO)
            c = DCS_CLI_ANCA;
        return c;
    endfunction : dcs_client_of

    // Spread per-client flags over their status bits
    function automatic logic [31:0] dcs_expand(
        input logic [DCS_NCLI-1:0] v);
        logic [31:0] r;
        r = '0;
        for (int unsigned i = 0; i < 32; i++)
            r[i] = v[dcs_client_of(i)];
        return r;
    endfunction : dcs_expand

    // Byte strobes to bit mask
    function automatic logic [31:0] dcs_strb_mask(input logic [3:0] s);
        logic [31:0] m;
        m = '0;
        for (int unsigned i = 0; i < 4; i++)
            m[i*8 +: 8] = {8{s[i]}};
        return m;
    endfunction : dcs_strb_mask

endpackage : dcs_pkg

`default_nettype wire

// ==== logic/dcs_sticky.sv ====
// Sticky write-one-to-clear status bits.
// Assumes set and clear vectors are synchronous single-cycle pulses.
`default_nettype none

module dcs_sticky
(
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic [31:0] i_set,
    input  wire logic [31:0] i_clr,
    output logic      [31:0] o_stat
);

    typedef struct packed {
        logic [31:0] stat;
    } dcs_sticky_st_t;

    dcs_sticky_st_t s_q;
    dcs_sticky_st_t s_d;

    always_comb
    begin
        s_d = s_q;
        // Set wins over a clear in the same cycle
        s_d.stat = (s_q.stat & ~i_clr) | i_set;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            s_q.stat <= dcs_pkg::DCS_STATUS_RST;
        else
            s_q <= s_d;
    end

    assign o_stat = s_q.stat;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    sticky_hold_a: assert property (
        ($past(o_stat) & ~$past(i_clr) & ~o_stat) == 32'h0000_0000)
        else $error("Status bit dropped without a clear");

    w1c_clear_a: assert property (
        ((i_clr & ~i_set) != 32'h0000_0000)
        |=> ((o_stat & $past(i_clr & ~i_set)) == 32'h0000_0000))
        else $error("Written one did not clear status bit");

endmodule : dcs_sticky

`default_nettype wire

// ==== verif/dcs_status_test.sv ====
// Self-checking bench for the DMA write completion status block.
// Assumes the design files under logic/ are compiled first.
`default_nettype none

module dcs_status_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  i_clk;
    logic                  i_nrst;
    dcs_pkg::dcs_axi_req_t req;
    dcs_pkg::dcs_axi_rsp_t rsp;
    logic [31:0]           last_wr;
    logic [2:0]            issue;
    logic [2:0]            ack;
    logic [2:0]            empty;
    logic                  irq;
    logic [31:0]           exp_st;
    int                    fail_count;
    int                    checked;

    dcs_status dut_u
    (
        .i_clk              (i_clk),
        .i_nrst             (i_nrst),
        .i_axi              (req),
        .o_axi              (rsp),
        .i_last_wr          (last_wr),
        .i_wr_issue         (issue),
        .i_wr_ack           (ack),
        .o_client_empty     (empty),
        .o_dma_irq_line_one (irq)
    );

    initial i_clk = 1'b0;
    always #12.5 i_clk = ~i_clk;

    task automatic conclude();
        $display("compares %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] want,
                         input string msg);
        checked++;
        if (seen !== want)
        begin
            fail_count++;
            $display("unexpected at %0t: %s %h not %h", $time, msg, seen,
                     want);
        end
    endtask : check

    // Write one word, answer is the write response
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                          input logic [3:0] s, input logic [1:0] er);
        int n;
        n = 0;
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= d;
        req.wstrb   <= s;
        req.bready  <= 1'b1;
        while (n < 50)
        begin
            @(posedge i_clk);
            n++;
            if (req.awvalid && rsp.awready)
                req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready)
                req.wvalid <= 1'b0;
            if (req.bready && rsp.bvalid)
            begin
                check({30'h0, rsp.bresp}, {30'h0, er}, "bresp");
                n = 99;
            end
        end
        if (n != 99)
            check(32'h0, 32'h1, "write stuck");
    endtask : axi_wr

    // Read one word and compare data and response
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] want,
                          input logic [1:0] er);
        int n;
        n = 0;
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        while (n < 50)
        begin
            @(posedge i_clk);
            n++;
            if (req.arvalid && rsp.arready)
                req.arvalid <= 1'b0;
            if (req.rready && rsp.rvalid)
            begin
                check(rsp.rdata, want, "rdata");
                check({30'h0, rsp.rresp}, {30'h0, er}, "rresp");
                n = 99;
            end
        end
        if (n != 99)
            check(32'h0, 32'h1, "read stuck");
    endtask : rd_chk

    task automatic t_reset();
        check({29'h0, empty}, 32'h7, "empty at reset");
        check({31'h0, irq}, 32'h0, "irq at reset");
        rd_chk(12'h0a0, 32'h0000_0000, 2'h0);
        rd_chk(12'h0a4, 32'h0000_0000, 2'h0);
    endtask : t_reset

    // Final write of a channel, acknowledged late by memory
    task automatic t_complete();
        int bits [6] = '{31, 22, 21, 6, 5, 0};
        int c;
        foreach (bits[i])
        begin
            c = (bits[i] >= 22) ? 0 : ((bits[i] >= 6) ? 1 : 2);
            issue   <= 3'h1 << c;
            last_wr <= 32'h1 << bits[i];
            @(posedge i_clk);
            issue   <= 3'h0;
            last_wr <= 32'h0;
            repeat (3) @(posedge i_clk);
            check({31'h0, empty[c]}, 32'h0, "busy client");
            rd_chk(12'h0a0, exp_st, 2'h0);
            ack <= 3'h1 << c;
            @(posedge i_clk);
            ack <= 3'h0;
            repeat (4) @(posedge i_clk);
            exp_st = exp_st | (32'h1 << bits[i]);
            check({31'h0, empty[c]}, 32'h1, "drained");
            rd_chk(12'h0a0, exp_st, 2'h0);
        end
    endtask : t_complete

    task automatic t_sticky();
        rd_chk(12'h0a0, exp_st, 2'h0);
        axi_wr(12'h0a0, 32'h0000_0000, 4'hf, 2'h0);
        axi_wr(12'h0a0, 32'h8000_0001, 4'h1, 2'h0);
        exp_st = exp_st & ~32'h0000_0001;
        rd_chk(12'h0a0, exp_st, 2'h0);
        // Acknowledge at zero count is ignored, the issue still counts
        issue <= 3'h7;
        ack   <= 3'h7;
        @(posedge i_clk);
        issue <= 3'h0;
        ack   <= 3'h0;
        @(posedge i_clk);
        check({29'h0, empty}, 32'h0, "refused ack");
        ack   <= 3'h7;
        @(posedge i_clk);
        ack   <= 3'h0;
        repeat (4) @(posedge i_clk);
        check({29'h0, empty}, 32'h7, "drained again");
        rd_chk(12'h0a0, exp_st, 2'h0);
        axi_wr(12'h0a0, 32'h8000_0000, 4'hf, 2'h0);
        exp_st = exp_st & ~32'h8000_0000;
        rd_chk(12'h0a0, exp_st, 2'h0);
    endtask : t_sticky

    task automatic t_irq();
        check({31'h0, irq}, 32'h0, "unmasked irq");
        axi_wr(12'h0a4, 32'h0000_0040, 4'hf, 2'h0);
        repeat (2) @(posedge i_clk);
        check({31'h0, irq}, 32'h1, "masked irq");
        axi_wr(12'h0a4, 32'h0000_0001, 4'hf, 2'h0);
        repeat (2) @(posedge i_clk);
        check({31'h0, irq}, 32'h0, "cleared bit irq");
        rd_chk(12'h0a4, 32'h0000_0001, 2'h0);
        axi_wr(12'h0a4, 32'h0000_0040, 4'hf, 2'h0);
        axi_wr(12'h0a0, 32'hffff_ffff, 4'hf, 2'h0);
        repeat (2) @(posedge i_clk);
        check({31'h0, irq}, 32'h0, "irq after clear");
        exp_st = 32'h0;
        rd_chk(12'h0a0, exp_st, 2'h0);
    endtask : t_irq

    task automatic t_unmapped();
        axi_wr(12'h0a8, 32'hffff_ffff, 4'hf, 2'h2);
        rd_chk(12'h0a8, 32'h0000_0000, 2'h2);
        rd_chk(12'h0a0, exp_st, 2'h0);
    endtask : t_unmapped

    initial
    begin
        #100000;
        fail_count++;
        conclude();
    end

    initial
    begin
        i_nrst     = 1'b0;
        req        = '0;
        last_wr    = 32'h0;
        issue      = 3'h0;
        ack        = 3'h0;
        exp_st     = 32'h0;
        fail_count = 0;
        checked    = 0;
        repeat (5) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        t_reset();
        t_complete();
        t_sticky();
        t_irq();
        t_unmapped();
        conclude();
    end

endmodule : dcs_status_test

`default_nettype wire
